// ===== include/fvs_cfg.svh
// constants for the full-voltage start/stop logic
`ifndef FVS_CFG_SVH
`define FVS_CFG_SVH

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define FVS_RST_RUN       1'b0
`define FVS_RST_ATSPEED   1'b0

// ---------------------------------------------------------------
// field positions of the protection enable vector
// ---------------------------------------------------------------
`define FVS_PROT_WIDTH    8
`define FVS_PROT_SCR_BIT  0
`define FVS_PROT_STK_BIT  1

// ---------------------------------------------------------------
// starter type encodings
// ---------------------------------------------------------------
`define FVS_TYPE_WIDTH    2
`define FVS_TYPE_SOFT     2'h0
`define FVS_TYPE_FULLV    2'h1
`define FVS_TYPE_WYEDELTA 2'h2

// ---------------------------------------------------------------
// gate and input widths
// ---------------------------------------------------------------
`define FVS_GATE_WIDTH    6
`define FVS_NUM_STOP      4

`endif

// ===== include/fvs_pkg.sv
// types for the full-voltage start/stop logic
`include "fvs_cfg.svh"

package fvs_pkg;

    // ---------------------------------------------------------------
    // run state of the starter
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        FVS_IDLE     = 2'b00,
        FVS_STARTING = 2'b01,
        FVS_AT_SPEED = 2'b10
    } fvs_state_t;

    // start/stop handling chosen at the start edge
    typedef enum logic {
        FVS_TWO_WIRE   = 1'b0,
        FVS_THREE_WIRE = 1'b1
    } fvs_wire_t;

endpackage : fvs_pkg

// ===== rtl/fvs_start_stop.sv
// full-voltage start/stop control with automatic two/three-wire handling
//
// What this block does
// [RQ1] In full-voltage mode a start command energizes the main-contactor run relay.
// [RQ2] In full-voltage mode the at-speed relays energize once full speed is judged.
// [RQ3] In full-voltage mode all protection stays on except thyristor and stack checks.
// [RQ4] In full-voltage mode ramp, kick and deceleration settings are ignored.
// [RQ5] In full-voltage mode all thyristor gate outputs are held off.
// [RQ6] Two-wire handling runs while the start input is held and stops when it drops.
// [RQ7] Three-wire handling starts on a start pulse and runs until a stop input is low.
// [RQ8] At each start rising edge, three-wire is chosen if a stop input is high.
// [RQ9] Three-wire handling latches the start request internally.
// [RQ10] Selector wiring holds the stop input high in local and low in remote.
// [RQ11] When running ends both run and at-speed relays drop in the same cycle.
`timescale 1ns/1ps
`default_nettype none

`include "fvs_cfg.svh"

module fvs_start_stop
    import fvs_pkg::*;
(
    input  wire logic                        clk,
    input  wire logic                        srst,
    input  wire logic [`FVS_TYPE_WIDTH-1:0]  starterType,
    input  wire logic                        firstDigitalInput,
    input  wire logic [`FVS_NUM_STOP-1:0]    stopInputs,
    input  wire logic [`FVS_NUM_STOP-1:0]    stopAssigned,
    input  wire logic                        fullSpeedSeen,
    input  wire logic                        faultTrip,
    input  wire logic [`FVS_PROT_WIDTH-1:0]  protEnableCfg,
    input  wire logic                        rampCfgActive,
    input  wire logic                        kickCfgActive,
    input  wire logic                        decelCfgActive,
    input  wire logic [`FVS_GATE_WIDTH-1:0]  gateFireReq,
    output logic                             mainContactor,
    output logic                             atSpeedOutput,
    output logic                             threeWireActive,
    output logic                             fullVoltageMode,
    output logic [`FVS_PROT_WIDTH-1:0]       protEnable,
    output logic                             rampEnable,
    output logic                             kickEnable,
    output logic                             decelEnable,
    output logic [`FVS_GATE_WIDTH-1:0]       gateFire
);

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    // true when any assigned stop input is high
    function automatic logic anyStopHigh(
        input logic [`FVS_NUM_STOP-1:0] lvl,
        input logic [`FVS_NUM_STOP-1:0] asg
    );
        anyStopHigh = |(lvl & asg);
    endfunction : anyStopHigh

    // true when any assigned stop input is low
    function automatic logic anyStopLow(
        input logic [`FVS_NUM_STOP-1:0] lvl,
        input logic [`FVS_NUM_STOP-1:0] asg
    );
        anyStopLow = |(~lvl & asg);
    endfunction : anyStopLow

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    logic                        startMeta_q;
    logic                        startSync_q;
    logic                        startPrev_q;
    logic [`FVS_NUM_STOP-1:0]    stopMeta_q;
    logic [`FVS_NUM_STOP-1:0]    stopSync_q;
    logic                        speedMeta_q;
    logic                        speedSync_q;

    // two flops per pin, then a delayed copy for edge detection
    always_ff @(posedge clk) begin
        if (srst) begin
            startMeta_q <= 1'b0;
            startSync_q <= 1'b0;
            startPrev_q <= 1'b0;
            stopMeta_q  <= '0;
            stopSync_q  <= '0;
            speedMeta_q <= 1'b0;
            speedSync_q <= 1'b0;
        end else begin
            startMeta_q <= firstDigitalInput;
            startSync_q <= startMeta_q;
            startPrev_q <= startSync_q;
            stopMeta_q  <= stopInputs;
            stopSync_q  <= stopMeta_q;
            speedMeta_q <= fullSpeedSeen;
            speedSync_q <= speedMeta_q;
        end
    end

    logic startRise;
    logic stopLowNow;
    logic stopHighNow;

    // start edge and stop levels
    assign startRise   = startSync_q & ~startPrev_q;
    assign stopLowNow  = anyStopLow(stopSync_q, stopAssigned);
    assign stopHighNow = anyStopHigh(stopSync_q, stopAssigned);

    assign fullVoltageMode = (starterType == `FVS_TYPE_FULLV);

    // ---------------------------------------------------------------
    // run state machine
    // ---------------------------------------------------------------
    fvs_state_t state_q;
    fvs_state_t state_d;
    fvs_wire_t  wire_q;
    fvs_wire_t  wire_d;
    logic       runEnd;

    // next state and wiring choice
    always_comb begin
        state_d = state_q;
        wire_d  = wire_q;
        runEnd  = 1'b0;
        if (startRise) begin
            // choose handling from stop level at the edge
            wire_d = stopHighNow ? FVS_THREE_WIRE : FVS_TWO_WIRE; // [RQ8]
        end
        unique case (state_q)
            FVS_IDLE: begin
                // a low stop only picks two-wire, it never blocks a start
                if (fullVoltageMode && startRise && !faultTrip) begin
                    state_d = FVS_STARTING; // [RQ1] [RQ9]
                end
            end
            FVS_STARTING, FVS_AT_SPEED: begin
                if (wire_q == FVS_TWO_WIRE) begin
                    runEnd = !startSync_q; // [RQ6]
                end else begin
                    runEnd = stopLowNow; // [RQ7]
                end
                if (faultTrip || !fullVoltageMode) begin
                    runEnd = 1'b1;
                end
                if (runEnd) begin
                    state_d = FVS_IDLE; // [RQ11]
                end else if (speedSync_q) begin
                    state_d = FVS_AT_SPEED; // [RQ2]
                end
            end
            default: begin
                state_d = FVS_IDLE;
            end
        endcase
    end

    // state registers
    always_ff @(posedge clk) begin
        if (srst) begin
            state_q <= FVS_IDLE;
            wire_q  <= FVS_TWO_WIRE;
        end else begin
            state_q <= state_d;
            wire_q  <= wire_d;
        end
    end

    // ---------------------------------------------------------------
    // relay outputs
    // ---------------------------------------------------------------
    logic runRelay_q;
    logic runRelay_d;
    logic speedRelay_q;
    logic speedRelay_d;

    // relays follow the next state so both drop together
    always_comb begin
        runRelay_d   = (state_d != FVS_IDLE); // [RQ1] [RQ11]
        speedRelay_d = (state_d == FVS_AT_SPEED); // [RQ2] [RQ11]
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            runRelay_q   <= `FVS_RST_RUN;
            speedRelay_q <= `FVS_RST_ATSPEED;
        end else begin
            runRelay_q   <= runRelay_d;
            speedRelay_q <= speedRelay_d;
        end
    end

    assign mainContactor   = runRelay_q;
    assign atSpeedOutput   = speedRelay_q;
    assign threeWireActive = (wire_q == FVS_THREE_WIRE);

    // ---------------------------------------------------------------
    // mode gating of protection, profile and gates
    // ---------------------------------------------------------------
    logic [`FVS_PROT_WIDTH-1:0] protMask;

    // inhibit thyristor and stack checks only in full-voltage mode
    always_comb begin
        protMask = '1;
        if (fullVoltageMode) begin
            protMask[`FVS_PROT_SCR_BIT] = 1'b0; // [RQ3]
            protMask[`FVS_PROT_STK_BIT] = 1'b0; // [RQ3]
        end
        protEnable  = protEnableCfg & protMask;
        rampEnable  = rampCfgActive & ~fullVoltageMode; // [RQ4]
        kickEnable  = kickCfgActive & ~fullVoltageMode; // [RQ4]
        decelEnable = decelCfgActive & ~fullVoltageMode; // [RQ4]
        gateFire    = fullVoltageMode ? '0 : gateFireReq; // [RQ5]
    end

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    a_gate_off_fv: assert property (@(posedge clk) disable iff (srst) // [RQ5]
        fullVoltageMode |-> gateFire == '0)
        else $error("gate fired in full-voltage mode");

    a_prot_inhibit: assert property (@(posedge clk) disable iff (srst) // [RQ3]
        fullVoltageMode |-> !protEnable[`FVS_PROT_SCR_BIT] &&
            !protEnable[`FVS_PROT_STK_BIT])
        else $error("thyristor checks active in full-voltage mode");

    a_profile_off: assert property (@(posedge clk) disable iff (srst) // [RQ4]
        fullVoltageMode |-> !(rampEnable | kickEnable | decelEnable))
        else $error("profile setting active in full-voltage mode");

    a_relays_drop: assert property (@(posedge clk) disable iff (srst) // [RQ11]
        $fell(mainContactor) |-> !atSpeedOutput && !$past(speedRelay_d))
        else $error("at-speed relay outlived run relay");

    a_speed_needs_run: assert property (@(posedge clk) disable iff (srst) // [RQ2]
        atSpeedOutput |-> mainContactor)
        else $error("at-speed without run");

    a_two_wire_stop: assert property (@(posedge clk) disable iff (srst) // [RQ6]
        mainContactor && wire_q == FVS_TWO_WIRE && !startSync_q
        |=> !mainContactor)
        else $error("two-wire run kept without command");

    a_three_wire_stop: assert property (@(posedge clk) disable iff (srst) // [RQ7]
        mainContactor && wire_q == FVS_THREE_WIRE && stopLowNow
        |=> !mainContactor)
        else $error("three-wire run kept with stop low");

    a_wire_select: assert property (@(posedge clk) disable iff (srst) // [RQ8]
        startRise |=> threeWireActive == $past(stopHighNow))
        else $error("wrong handling chosen at start edge");

    a_start_run: assert property (@(posedge clk) disable iff (srst) // [RQ1]
        state_q == FVS_IDLE && fullVoltageMode && startRise && !faultTrip
        |=> mainContactor)
        else $error("start did not energise run relay");

    a_seal_in: assert property (@(posedge clk) disable iff (srst) // [RQ9]
        mainContactor && threeWireActive && !startSync_q && !stopLowNow &&
        !faultTrip && fullVoltageMode |=> mainContactor)
        else $error("three-wire run not held after release");

endmodule : fvs_start_stop

`default_nettype wire

// ===== verification/fvs_panel_model.sv
// operator panel model: selector, pushbuttons and run contact
`timescale 1ns/1ps
`default_nettype none

module fvs_panel_model (
    input  wire logic       handPos,
    input  wire logic       stopPress,
    input  wire logic       startPress,
    input  wire logic       plcRun,
    output logic            startPin,
    output logic [3:0]      stopPins
);
    // ---------------------------------------------------------------
    // selector wiring
    // ---------------------------------------------------------------
    logic stopLevel;

    // stop contact fed only in local position, low in remote
    assign stopLevel = handPos & ~stopPress;
    // stop wired ahead of start, so a held stop blocks the start button
    assign startPin  = handPos ? (startPress & stopLevel) : plcRun;
    assign stopPins  = {3'h0, stopLevel};
endmodule : fvs_panel_model

`default_nettype wire

// ===== verification/full_voltage_start_stop_test.sv
// self-checking testbench for the full-voltage start/stop logic
`timescale 1ns/1ps
`default_nettype none
`include "fvs_cfg.svh"

module full_voltage_start_stop_test
    import fvs_pkg::*;
;
    // ---------------------------------------------------------------
    // signals
    // ---------------------------------------------------------------
    logic       clk = 1'b0;
    logic       srst = 1'b1;
    logic [1:0] starterType = `FVS_TYPE_SOFT;
    logic [3:0] stopAssigned = 4'h1;
    logic       fullSpeedSeen = 1'b0;
    logic       faultTrip = 1'b0;
    logic [7:0] protEnableCfg = 8'hff;
    logic       rampCfgActive = 1'b1;
    logic       kickCfgActive = 1'b1;
    logic       decelCfgActive = 1'b1;
    logic [5:0] gateFireReq = 6'h3f;
    logic       handPos = 1'b0;
    logic       stopPress = 1'b0;
    logic       startPress = 1'b0;
    logic       plcRun = 1'b0;
    logic       firstDigitalInput;
    logic [3:0] stopInputs;
    logic       mainContactor;
    logic       atSpeedOutput;
    logic       threeWireActive;
    logic       fullVoltageMode;
    logic [7:0] protEnable;
    logic       rampEnable;
    logic       kickEnable;
    logic       decelEnable;
    logic [5:0] gateFire;
    int         error_cnt = 0;
    int         compares = 0;

    // 25 MHz clock
    always #20 clk = ~clk;

    fvs_panel_model panel (.handPos(handPos), .stopPress(stopPress),
        .startPress(startPress), .plcRun(plcRun),
        .startPin(firstDigitalInput), .stopPins(stopInputs));

    fvs_start_stop dut (.clk(clk), .srst(srst), .starterType(starterType),
        .firstDigitalInput(firstDigitalInput), .stopInputs(stopInputs),
        .stopAssigned(stopAssigned), .fullSpeedSeen(fullSpeedSeen),
        .faultTrip(faultTrip), .protEnableCfg(protEnableCfg),
        .rampCfgActive(rampCfgActive), .kickCfgActive(kickCfgActive),
        .decelCfgActive(decelCfgActive), .gateFireReq(gateFireReq),
        .mainContactor(mainContactor), .atSpeedOutput(atSpeedOutput),
        .threeWireActive(threeWireActive), .fullVoltageMode(fullVoltageMode),
        .protEnable(protEnable), .rampEnable(rampEnable),
        .kickEnable(kickEnable), .decelEnable(decelEnable),
        .gateFire(gateFire));

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    task automatic summarize();
        $display("checks %0d, mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize

    task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                         input string msg);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask : check

    // inputs move 1 ns after the rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    // bounded wait for the run relay to reach a level
    task automatic waitRun(input logic val);
        int i;
        i = 0;
        while (mainContactor !== val && i < 12) begin
            tick(1);
            i++;
        end
        if (mainContactor !== val) begin
            error_cnt++;
            $display("unexpected at %0t: run relay wait ran out", $time);
            summarize();
        end
    endtask : waitRun

    task automatic pressStart();
        startPress = 1'b1;
        tick(2);
        startPress = 1'b0;
    endtask : pressStart

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic test_modes();
        logic fv;
        for (int t = 0; t < 4; t++) begin
            starterType = t[1:0];
            tick(1);
            fv = (t == 1);
            check(fullVoltageMode, fv, "mode flag");
            check(protEnable, fv ? 8'hfc : 8'hff, "protection");
            check({rampEnable, kickEnable, decelEnable},
                  fv ? 8'h00 : 8'h07, "profile");
            check(gateFire, fv ? 8'h00 : 8'h3f, "gates");
        end
        starterType = `FVS_TYPE_SOFT;
        plcRun = 1'b1;
        tick(6);
        check(mainContactor, 1'b0, "start outside mode");
        plcRun = 1'b0;
        tick(4);
        $display("test modes done");
    endtask : test_modes

    task automatic test_three();
        starterType = `FVS_TYPE_FULLV;
        handPos = 1'b1;
        tick(3);
        pressStart();
        waitRun(1'b1);
        check(threeWireActive, 1'b1, "three-wire chosen");
        tick(6);
        check(mainContactor, 1'b1, "latched run");
        check(atSpeedOutput, 1'b0, "early at-speed");
        fullSpeedSeen = 1'b1;
        tick(4);
        check(atSpeedOutput, 1'b1, "at-speed relay");
        stopPress = 1'b1;
        waitRun(1'b0);
        check(atSpeedOutput, 1'b0, "at-speed with run");
        stopPress = 1'b0;
        fullSpeedSeen = 1'b0;
        tick(4);
        $display("test three-wire done");
    endtask : test_three

    task automatic test_two();
        handPos = 1'b0;
        tick(3);
        plcRun = 1'b1;
        waitRun(1'b1);
        check(threeWireActive, 1'b0, "two-wire chosen");
        fullSpeedSeen = 1'b1;
        tick(4);
        check(atSpeedOutput, 1'b1, "at-speed relay");
        plcRun = 1'b0;
        waitRun(1'b0);
        check(atSpeedOutput, 1'b0, "at-speed with run");
        tick(4);
        $display("test two-wire done");
    endtask : test_two

    task automatic test_fault();
        handPos = 1'b1;
        tick(3);
        pressStart();
        waitRun(1'b1);
        tick(4);
        faultTrip = 1'b1;
        waitRun(1'b0);
        check(atSpeedOutput, 1'b0, "fault drop");
        tick(3);
        pressStart();
        tick(4);
        check(mainContactor, 1'b0, "start while faulted");
        faultTrip = 1'b0;
        tick(3);
        pressStart();
        waitRun(1'b1);
        tick(4);
        starterType = `FVS_TYPE_WYEDELTA;
        waitRun(1'b0);
        check(atSpeedOutput, 1'b0, "mode left drop");
        $display("test fault done");
    endtask : test_fault

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        tick(8);
        check(mainContactor, `FVS_RST_RUN, "run reset");
        check(atSpeedOutput, `FVS_RST_ATSPEED, "at-speed reset");
        srst = 1'b0;
        tick(2);
        test_modes();
        test_three();
        test_two();
        test_fault();
        summarize();
    end
endmodule : full_voltage_start_stop_test

`default_nettype wire
